// ---- include/aru_defs.svh ----
`ifndef ARU_DEFS_SVH
`define ARU_DEFS_SVH

// Register offsets on the control port (byte addresses)
`define ARU_OFF_CTRL        8'h00
`define ARU_OFF_STATUS      8'h04
`define ARU_OFF_CHEN_LO     8'h08
`define ARU_OFF_CHEN_HI     8'h0C
`define ARU_OFF_IRQ_STAT    8'h10
`define ARU_OFF_IRQ_MASK    8'h14

// Control register action bits
`define ARU_CTRL_ENABLE     0
`define ARU_CTRL_SETUP_SET  1
`define ARU_CTRL_SETUP_CLR  2

// Status register bits
`define ARU_STAT_ENABLED    0
`define ARU_STAT_SETUP      1
`define ARU_STAT_BUSY       2

// Interrupt event bits
`define ARU_EV_CH_OFF       0
`define ARU_EV_RANGE        1
`define ARU_EV_DONE         2
`define ARU_EV_COUNT        3

// Lowest target address the unit can remap to
`define ARU_REMAP_BASE      32'hFFFC0000

// Reset values
`define ARU_RST_WORD        32'h00000000
`define ARU_RST_CHEN        64'h0000000000000000

`endif

// ---- include/aru_pkg.sv ----
package aru_pkg;

  // Forwarding sequencer states
  typedef enum logic [1:0] {
    ARU_IDLE  = 2'b00,
    ARU_ISSUE = 2'b01,
    ARU_WAIT  = 2'b10
  } aru_state_type;

endpackage

// ---- rtl/aru_irq.sv ----
`timescale 1ns/10ps
`include "aru_defs.svh"

// Sticky event flags, mask and one level interrupt output
module aru_irq #(
  parameter int WIDTH = `ARU_EV_COUNT
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Flags only move while the high-speed clock runs
  input  wire logic             i_run,
  // Event pulses from the unit
  input  wire logic [WIDTH-1:0] i_event,
  // Software access
  input  wire logic             i_stat_wr,
  input  wire logic             i_mask_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // State seen by software and the interrupt controller
  output logic      [WIDTH-1:0] o_stat,
  output logic      [WIDTH-1:0] o_mask,
  output logic                  o_irq
);

  // Elaboration check: flags and mask each fit in one 32-bit register word
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("aru_irq: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stat;  // Sticky flags
    logic [WIDTH-1:0] mask;  // Enables onto the output
    logic             irq;   // Registered request line
  } aru_irq_state_type;

  aru_irq_state_type s_q;
  aru_irq_state_type s_d;

  // Next state; a set in the clearing cycle wins so no event is lost
  always_comb begin
    s_d = s_q;
    if (i_run) begin
      if (i_stat_wr) begin
        s_d.stat = (s_q.stat & ~i_wdata) | i_event;
      end else begin
        s_d.stat = s_q.stat | i_event;
      end
      if (i_mask_wr) begin
        s_d.mask = i_wdata;
      end
    end
    s_d.irq = |(s_d.stat & s_d.mask);  // [RULE12]
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_stat = s_q.stat;
  assign o_mask = s_q.mask;
  assign o_irq  = s_q.irq;

endmodule

// ---- rtl/aru_range_chk.sv ----
`timescale 1ns/10ps
`include "aru_defs.svh"

// Tells whether a remap target lies in the reachable region
module aru_range_chk (
  // Target address under test
  input  wire logic [31:0] i_target,
  // High when the unit may forward there
  output logic             o_ok
);

  // Only the top of the map is wired to the peripheral bus bridge
  assign o_ok = (i_target >= `ARU_REMAP_BASE);  // [RULE8]

endmodule

// ---- rtl/aru_access_remap_unit.sv ----
// How it works
// RULE1 - Enable write sets the enabled status flag
// RULE2 - Remap target decoded at its channel address
// RULE3 - Normal mode hits channel, setup hits target
// RULE4 - Setup-set bit switches unit into setup mode
// RULE5 - Setup-clear bit returns unit to normal mode
// RULE6 - Channel enable bits, low and high halves
// RULE7 - Software programs targets, then enables channels
// RULE8 - Only targets above the base are reachable; the range check also accepts the base itself
// RULE9 - Halts while clocks stop, resumes unchanged
// RULE10 - Two bus clocks, both running after reset
// RULE11 - Software keeps high-speed clock on while pending
// RULE12 - One interrupt request output
// RULE13 - Keeps working while processor is debugged
// RULE14 - Enabled channel access forwarded to its target
`timescale 1ns/10ps
`include "aru_defs.svh"

module aru_access_remap_unit #(
  parameter int NUM_CHANNELS = 16
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  // Bus clock run levels from power management
  input  wire logic                       i_hsb_clk_run,
  input  wire logic                       i_pb_clk_run,
  // Control register port
  input  wire logic [7:0]                 i_reg_addr,
  input  wire logic [31:0]                i_reg_wdata,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  output logic      [31:0]                o_reg_rdata,
  // High-speed bus channel window
  input  wire logic [$clog2(NUM_CHANNELS)+1:0] i_hs_addr,
  input  wire logic [31:0]                i_hs_wdata,
  input  wire logic                       i_hs_wr,
  input  wire logic                       i_hs_rd,
  output logic      [31:0]                o_hs_rdata,
  output logic                            o_hs_done,
  output logic                            o_hs_err,
  output logic                            o_hs_busy,
  // Peripheral bus master side
  output logic      [31:0]                o_pb_addr,
  output logic      [31:0]                o_pb_wdata,
  output logic                            o_pb_wr,
  output logic                            o_pb_rd,
  input  wire logic [31:0]                i_pb_rdata,
  input  wire logic                       i_pb_ready,
  // Interrupt request
  output logic                            o_irq
);

  // Channel index width; the byte address adds two low bits to it
  localparam int CIW = $clog2(NUM_CHANNELS);

  // Enable registers hold 64 bits, and an index needs at least one bit;
  // a count that is not a power of two would let an address index past
  // the last remap target, so such counts are refused
  if (NUM_CHANNELS < 2 || NUM_CHANNELS > 64) begin : g_bad_count
    $error("aru: NUM_CHANNELS must be 2..64");
  end
  if ((NUM_CHANNELS & (NUM_CHANNELS - 1)) != 0) begin : g_not_pow2
    $error("aru: NUM_CHANNELS must be a power of two");
  end

  // Whole state of the unit. Targets sit in flip-flops, not a memory, so a
  // setup read and a forward see any target at once; each channel costs
  // 32 flops; the count is capped at 64 by the 64 channel enable bits
  typedef struct packed {
    logic                         enabled;   // Unit switched on
    logic                         setup;     // Setup mode active
    logic [63:0]                  chen;      // Channel enables, high:low
    logic [NUM_CHANNELS-1:0][31:0] remap_target_reg;      // Remap target per channel
    aru_pkg::aru_state_type       st;        // Forwarding sequencer
    logic [31:0]                  reg_rdata; // Control port read data
    logic [31:0]                  hs_rdata;  // Channel read data
    logic                         hs_done;   // Channel answer pulse
    logic                         hs_err;    // Channel answer is an error
    logic                         hs_busy;   // Channel access in progress
    logic [31:0]                  pb_addr;   // Forward target address
    logic [31:0]                  pb_wdata;  // Forward write data
    logic                         pb_wr;     // Forward write strobe
    logic                         pb_rd;     // Forward read strobe
    logic                         fwd_wr;    // Latched direction of access
  } aru_state_s_type;

  // Registered state and its next value
  aru_state_s_type s_q;
  aru_state_s_type s_d;

  // Channel decode from the word address
  logic [CIW-1:0]           hs_idx;
  logic [31:0]              hs_target;
  logic                     hs_target_ok;
  logic                     hs_req;
  logic                     hs_ch_on;
  // Interrupt side
  logic [`ARU_EV_COUNT-1:0] ev;
  logic [`ARU_EV_COUNT-1:0] irq_stat;
  logic [`ARU_EV_COUNT-1:0] irq_mask;
  logic                     irq_stat_wr;
  logic                     irq_mask_wr;
  // Status word assembled for reads
  logic [31:0]              status_word;

  // Channel index from the word address; the two byte-lane bits are
  // ignored, so every byte of a channel word selects the same channel.
  // Requests that arrive while a forward is open are dropped, not queued:
  // the bus master has to wait for the answer first.
  assign hs_idx    = i_hs_addr[CIW+1:2];      // [RULE2]
  assign hs_target = s_q.remap_target_reg[hs_idx];
  assign hs_req    = (i_hs_wr || i_hs_rd) && !s_q.hs_busy;
  assign hs_ch_on  = s_q.chen[6'(hs_idx)];

  // Range check of the selected channel target. It matters only when the
  // target is used, so software may park any value while in setup mode.
  aru_range_chk u_range (
    .i_target (hs_target),
    .o_ok     (hs_target_ok)
  );

  // Register writes into the interrupt block
  assign irq_stat_wr = i_reg_wr && (i_reg_addr == `ARU_OFF_IRQ_STAT);
  assign irq_mask_wr = i_reg_wr && (i_reg_addr == `ARU_OFF_IRQ_MASK);

  // Status word
  // Read-only view; unused bits read as zero
  always_comb begin
    status_word                      = `ARU_RST_WORD;
    status_word[`ARU_STAT_ENABLED]   = s_q.enabled;
    status_word[`ARU_STAT_SETUP]     = s_q.setup;
    status_word[`ARU_STAT_BUSY]      = s_q.hs_busy;
  end

  // A stopped high-speed clock is seen as a low run level: every field
  // holds, and one-cycle pulses drop so that no strobe is repeated once
  // the clock comes back.
  // Next state of the whole unit; no input tied to processor debug
  // state, so a halted core does not disturb forwarding [RULE13]
  always_comb begin
    s_d         = s_q;
    ev          = '0;
    // Pulses default low, so each lasts exactly one cycle
    s_d.hs_done = 1'b0;
    s_d.pb_wr   = 1'b0;
    s_d.pb_rd   = 1'b0;
    if (!i_hsb_clk_run) begin
      // High-speed clock stopped: everything freezes, pulses drop [RULE9]
      s_d = s_q;
      s_d.hs_done = 1'b0;
      s_d.pb_wr   = 1'b0;
      s_d.pb_rd   = 1'b0;
    end else begin
      // Control register port writes
      if (i_reg_wr) begin
        case (i_reg_addr)
          `ARU_OFF_CTRL: begin
            if (i_reg_wdata[`ARU_CTRL_ENABLE]) begin
              s_d.enabled = 1'b1;                    // [RULE1]
            end
            if (i_reg_wdata[`ARU_CTRL_SETUP_SET]) begin
              s_d.setup = 1'b1;                      // [RULE4]
            end
            // Clear wins if both action bits are written together
            if (i_reg_wdata[`ARU_CTRL_SETUP_CLR]) begin
              s_d.setup = 1'b0;                      // [RULE5]
            end
          end
          // Halves written apart; a 32-bit port cannot set all 64 at once
          `ARU_OFF_CHEN_LO: begin
            s_d.chen[31:0] = i_reg_wdata;            // [RULE6]
          end
          `ARU_OFF_CHEN_HI: begin
            s_d.chen[63:32] = i_reg_wdata;           // [RULE6]
          end
          default: begin
            // Other offsets store nothing here
          end
        endcase
      end
      // Control register port reads, answered one cycle later
      if (i_reg_rd) begin
        case (i_reg_addr)
          `ARU_OFF_STATUS:   s_d.reg_rdata = status_word;
          `ARU_OFF_CHEN_LO:  s_d.reg_rdata = s_q.chen[31:0];
          `ARU_OFF_CHEN_HI:  s_d.reg_rdata = s_q.chen[63:32];
          `ARU_OFF_IRQ_STAT: s_d.reg_rdata = {{(32-`ARU_EV_COUNT){1'b0}}, irq_stat};
          `ARU_OFF_IRQ_MASK: s_d.reg_rdata = {{(32-`ARU_EV_COUNT){1'b0}}, irq_mask};
          default:           s_d.reg_rdata = `ARU_RST_WORD;
        endcase
      end else begin
        // Zero outside the answer cycle, so a stale word never looks fresh
        s_d.reg_rdata = `ARU_RST_WORD;
      end
      // Channel window sequencer. Setup and refused accesses answer in one
      // cycle; a forward takes issue, strobe and answer cycles at least, plus
      // any wait the peripheral side adds before it raises ready
      case (s_q.st)
        aru_pkg::ARU_IDLE: begin
          if (hs_req) begin
            s_d.hs_err = 1'b0;
            if (s_q.setup) begin
              // Setup mode: the same address reaches the target register [RULE3]
              if (i_hs_wr) begin
                s_d.remap_target_reg[hs_idx] = i_hs_wdata;        // [RULE2]
              end else begin
                s_d.hs_rdata = hs_target;
              end
              s_d.hs_done = 1'b1;
            end else if (!s_q.enabled || !hs_ch_on) begin
              // Unit or channel off: refuse at once
              s_d.hs_err            = 1'b1;
              s_d.hs_done           = 1'b1;
              ev[`ARU_EV_CH_OFF]    = 1'b1;
            end else if (!hs_target_ok) begin
              // Target outside the reachable region
              s_d.hs_err            = 1'b1;
              s_d.hs_done           = 1'b1;
              ev[`ARU_EV_RANGE]     = 1'b1;          // [RULE8]
            end else begin
              // Normal mode: access goes to the channel [RULE3]
              s_d.pb_addr  = hs_target;              // [RULE14]
              s_d.pb_wdata = i_hs_wdata;
              s_d.fwd_wr   = i_hs_wr;
              s_d.hs_busy  = 1'b1;
              s_d.st       = aru_pkg::ARU_ISSUE;
            end
          end
        end
        aru_pkg::ARU_ISSUE: begin
          // Wait for the peripheral clock before driving a strobe [RULE10]
          // Address and data were latched on entry and stay put meanwhile
          if (i_pb_clk_run) begin
            s_d.pb_wr = s_q.fwd_wr;                  // [RULE14]
            s_d.pb_rd = !s_q.fwd_wr;
            s_d.st    = aru_pkg::ARU_WAIT;
          end
        end
        aru_pkg::ARU_WAIT: begin
          // Holds the access open; stopping the clock here would hang it [RULE11]
          // No timeout: a peripheral that never answers keeps the window
          // busy until reset, the price of keeping the handshake simple
          if (i_pb_ready) begin
            s_d.hs_rdata       = s_q.fwd_wr ? `ARU_RST_WORD : i_pb_rdata;  // [RULE14]
            s_d.hs_done        = 1'b1;
            s_d.hs_busy        = 1'b0;
            ev[`ARU_EV_DONE]   = 1'b1;
            s_d.st             = aru_pkg::ARU_IDLE;
          end
        end
        default: begin
          // Unused code: back to idle, dropping any half-done forward
          s_d.st      = aru_pkg::ARU_IDLE;
          s_d.hs_busy = 1'b0;
        end
      endcase
    end
  end

  // State register; both bus clocks count as running from reset [RULE10]
  // Reset needs no clock, so the unit comes up disabled, in normal mode,
  // with every channel off even while the high-speed clock is stopped
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q      <= '0;
      s_q.st   <= aru_pkg::ARU_IDLE;
      s_q.chen <= `ARU_RST_CHEN;
    end else begin
      s_q <= s_d;
    end
  end

  // Sticky flags, mask and the single request line
  // Events are one-cycle pulses from the next-state logic; the flag block
  // makes them sticky and registers the request so it comes from a flop
  aru_irq #(
    .WIDTH (`ARU_EV_COUNT)
  ) u_irq (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_run     (i_hsb_clk_run),
    .i_event   (ev),
    .i_stat_wr (irq_stat_wr),
    .i_mask_wr (irq_mask_wr),
    .i_wdata   (i_reg_wdata[`ARU_EV_COUNT-1:0]),
    .o_stat    (irq_stat),
    .o_mask    (irq_mask),
    .o_irq     (o_irq)                               // [RULE12]
  );

  // Outputs straight from the state register
  // No logic between flops and pins, so output timing is one clock-to-out
  assign o_reg_rdata = s_q.reg_rdata;
  assign o_hs_rdata  = s_q.hs_rdata;
  assign o_hs_done   = s_q.hs_done;
  assign o_hs_err    = s_q.hs_err;
  assign o_hs_busy   = s_q.hs_busy;
  assign o_pb_addr   = s_q.pb_addr;
  assign o_pb_wdata  = s_q.pb_wdata;
  assign o_pb_wr     = s_q.pb_wr;
  assign o_pb_rd     = s_q.pb_rd;

endmodule

// ---- dv/aru_chk.sv ----
`timescale 1ns/10ps
`include "aru_defs.svh"

// Port checker for the remap unit, bound to the top module
module aru_chk (
  // Clock, reset and run levels
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_hsb_clk_run,
  // Bus inputs that start answers
  input wire logic        i_reg_rd,
  input wire logic        i_pb_ready,
  // Watched outputs
  input wire logic        o_hs_done,
  input wire logic        o_hs_err,
  input wire logic        o_hs_busy,
  input wire logic        o_pb_wr,
  input wire logic        o_pb_rd,
  input wire logic        o_irq,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [31:0] o_pb_addr
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_rdz; !$past(i_reg_rd) |-> o_reg_rdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside its answer cycle");
  property p_frz; !i_hsb_clk_run |=> $stable(o_hs_busy) && $stable(o_pb_addr); endproperty
  a_frz: assert property (p_frz) else $error("state moved while clock stopped");
  property p_fwd; $rose(o_hs_busy) |-> ##[1:16] (o_pb_rd || o_pb_wr); endproperty
  a_fwd: assert property (p_fwd) else $error("no peripheral strobe after forward start");
  property p_done; i_pb_ready && o_hs_busy && i_hsb_clk_run |=> o_hs_done && !o_hs_busy; endproperty
  a_done: assert property (p_done) else $error("no answer after peripheral ready");
  property p_idle; o_hs_done |-> !o_hs_busy; endproperty
  a_idle: assert property (p_idle) else $error("busy beside answer");
  property p_strb; o_pb_rd || o_pb_wr |=> !o_pb_rd && !o_pb_wr; endproperty
  a_strb: assert property (p_strb) else $error("peripheral strobe longer than one cycle");
  property p_rng; o_pb_rd || o_pb_wr |-> o_pb_addr >= `ARU_REMAP_BASE && o_hs_busy; endproperty
  a_rng: assert property (p_rng) else $error("forward to unreachable target");
  property p_err; $rose(o_hs_err) |-> o_hs_done; endproperty
  a_err: assert property (p_err) else $error("error flag without answer");

  // Main scenarios
  c_fwd: cover property (o_pb_rd ##[1:8] o_hs_done);
  c_ref: cover property (o_hs_done && o_hs_err);
  c_irq: cover property ($rose(o_irq));
endmodule

bind aru_access_remap_unit aru_chk chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_hsb_clk_run(i_hsb_clk_run),
  .i_reg_rd(i_reg_rd), .i_pb_ready(i_pb_ready), .o_hs_done(o_hs_done), .o_hs_err(o_hs_err),
  .o_hs_busy(o_hs_busy), .o_pb_wr(o_pb_wr), .o_pb_rd(o_pb_rd), .o_irq(o_irq),
  .o_reg_rdata(o_reg_rdata), .o_pb_addr(o_pb_addr));

// ---- dv/aru_pb_model.sv ----
`timescale 1ns/10ps

// Peripheral register file behind the unit, answering after a chosen delay
module aru_pb_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [2:0]  i_lat,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_ready
);
  logic [31:0] mem_q [16]; // Word store indexed by target bits 5..2
  logic [2:0]  cnt_q;      // Cycles left before answering
  logic        pend_q;     // Access awaiting its answer
  logic        rd_q;       // Pending access is a read

  // Strobe capture, delay and one-cycle ready pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= 32'h0;
      cnt_q   <= 3'h0;
      pend_q  <= 1'b0;
      rd_q    <= 1'b0;
      o_ready <= 1'b0;
      o_rdata <= 32'h0;
    end else begin
      o_ready <= 1'b0;
      // Idle data lines toggle so stale values never look valid
      o_rdata <= ~o_rdata;
      if (i_wr || i_rd) begin
        pend_q <= 1'b1;
        cnt_q  <= i_lat;
        rd_q   <= i_rd;
        if (i_wr) mem_q[i_addr[5:2]] <= i_wdata;
      end else if (pend_q && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (pend_q) begin
        pend_q  <= 1'b0;
        o_ready <= 1'b1;
        if (rd_q) o_rdata <= mem_q[i_addr[5:2]];
      end
    end
  end
endmodule

// ---- dv/aru_access_remap_unit_test.sv ----
`timescale 1ns/10ps
`include "aru_defs.svh"

module aru_access_remap_unit_test;
  logic        i_clk = 0, i_reset = 1, run_hs = 1, run_pb = 1, r_wr = 0, r_rd = 0, hs_wr = 0, hs_rd = 0;
  logic        done, err, busy, pb_wr, pb_rd, pb_ready, irq, rd_d = 0;
  logic [7:0]  r_addr = 0;
  logic [5:0]  hs_addr = 0;
  logic [2:0]  lat = 0;
  logic [31:0] r_wdata = 0, hs_wdata = 0, rdata, hs_rdata, pb_addr, pb_wdata, pb_rdata, d;
  logic [31:0] tgt [4];
  logic [32:0] rq [$];  // Expected register read data
  logic [32:0] hq [$];  // Expected channel answer: error flag over data
  int          n_fail = 0, samples_checked = 0;
  localparam logic [32:0] REF = 33'h1_0000_0000;

  always #5 i_clk = ~i_clk;

  aru_access_remap_unit dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_hsb_clk_run(run_hs), .i_pb_clk_run(run_pb),
    .i_reg_addr(r_addr), .i_reg_wdata(r_wdata), .i_reg_wr(r_wr), .i_reg_rd(r_rd), .o_reg_rdata(rdata),
    .i_hs_addr(hs_addr), .i_hs_wdata(hs_wdata), .i_hs_wr(hs_wr), .i_hs_rd(hs_rd), .o_hs_rdata(hs_rdata),
    .o_hs_done(done), .o_hs_err(err), .o_hs_busy(busy), .o_pb_addr(pb_addr), .o_pb_wdata(pb_wdata),
    .o_pb_wr(pb_wr), .o_pb_rd(pb_rd), .i_pb_rdata(pb_rdata), .i_pb_ready(pb_ready), .o_irq(irq));
  aru_pb_model pb_u (.i_clk(i_clk), .i_reset(i_reset), .i_lat(lat), .i_addr(pb_addr), .i_wdata(pb_wdata),
    .i_wr(pb_wr), .i_rd(pb_rd), .o_rdata(pb_rdata), .o_ready(pb_ready));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One-cycle strobes with a gap edge so no strobe is set twice in a step
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    r_addr <= a; r_wdata <= v; r_wr <= 1'b1;
    @(posedge i_clk); r_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back({1'b0, e}); r_addr <= a; r_rd <= 1'b1;
    @(posedge i_clk); r_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic hs(input logic w, input logic [3:0] ch, input logic [31:0] v, input logic [32:0] e);
    int n;
    hq.push_back(e); lat <= 3'($urandom_range(4)); hs_addr <= {ch, 2'b00}; hs_wdata <= v; hs_wr <= w; hs_rd <= !w;
    @(posedge i_clk); hs_wr <= 1'b0; hs_rd <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    if (done !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: channel access not answered", $time);
    end
    @(posedge i_clk);
  endtask

  // Peripheral clock stalls at random; it only delays the strobe
  always @(posedge i_clk) begin
    run_pb <= ($urandom_range(3) != 0);
    rd_d   <= r_rd && run_hs;
  end

  // Result watcher: oldest note against each answer, at mid-cycle
  always @(negedge i_clk) begin
    logic [32:0] e;
    if (rd_d) begin
      e = rq.pop_front();
      cmp(rdata, e[31:0]);
    end
    if (done === 1'b1) begin
      e = hq.pop_front();
      cmp_bit(err, e[32]);
      if (!e[32]) cmp(hs_rdata, e[31:0]);
    end
  end

  initial begin
    void'($urandom(32'hae9c));
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    reg_rd(`ARU_OFF_STATUS, 32'h0);
    reg_rd(8'h18, 32'h0);
    hs(1'b0, 4'h1, 32'h0, REF);
    reg_wr(`ARU_OFF_CTRL, 32'h1);
    reg_rd(`ARU_OFF_STATUS, 32'h1);
    reg_wr(`ARU_OFF_CTRL, 32'h2);
    reg_rd(`ARU_OFF_STATUS, 32'h3);
    // Every target programmed in setup mode before any channel is enabled
    // A setup write leaves the answer data holding the previous read
    for (int c = 0; c < 4; c++) begin
      tgt[c] = (c == 3) ? 32'h0000_1000 : `ARU_REMAP_BASE + (($urandom & 32'hFFF) << 6) + 32'(c * 4);
      hs(1'b1, 4'(c), tgt[c], {1'b0, (c == 0) ? 32'h0 : tgt[c - 1]});
      hs(1'b0, 4'(c), 32'h0, {1'b0, tgt[c]});
    end
    reg_wr(`ARU_OFF_CTRL, 32'h4);
    reg_rd(`ARU_OFF_STATUS, 32'h1);
    hs(1'b0, 4'h0, 32'h0, REF);
    reg_wr(`ARU_OFF_CHEN_LO, 32'hF);
    reg_rd(`ARU_OFF_CHEN_LO, 32'hF);
    for (int c = 0; c < 3; c++) begin
      d = $urandom;
      hs(1'b1, 4'(c), d, 33'h0);
      hs(1'b0, 4'(c), 32'h0, {1'b0, d});
    end
    hs(1'b0, 4'h3, 32'h0, REF);
    reg_rd(`ARU_OFF_IRQ_STAT, 32'h7);
    reg_wr(`ARU_OFF_IRQ_MASK, 32'h2);
    @(negedge i_clk) cmp_bit(irq, 1'b1);
    @(posedge i_clk) reg_wr(`ARU_OFF_IRQ_STAT, 32'h2);
    @(negedge i_clk) cmp_bit(irq, 1'b0);
    @(posedge i_clk) reg_rd(`ARU_OFF_IRQ_STAT, 32'h5);
    // Clock stopped while idle: writes are lost, setup stays as it was
    run_hs <= 1'b0; // Only stopped with no access pending
    reg_wr(`ARU_OFF_CTRL, 32'h2);
    run_hs <= 1'b1;
    reg_rd(`ARU_OFF_STATUS, 32'h1);
    hs(1'b0, 4'h2, 32'h0, {1'b0, d});
    i_reset <= 1'b1;
    @(posedge i_clk) i_reset <= 1'b0;
    @(posedge i_clk) reg_rd(`ARU_OFF_STATUS, 32'h0);
    reg_rd(`ARU_OFF_CHEN_LO, 32'h0);
    give_verdict;
  end

  // Hang guard, far beyond the roughly 120 cycles the tests need
  initial begin
    #100000;
    n_fail++;
    give_verdict;
  end
endmodule
